// [logic/emc_ctrl.sv]
// emulation memory control: host access, mapper, pager, strobes, break
`timescale 1ns/1ns
// Function
// - drive break status low when this block caused the emulator break
// - one shared 16-bit active-low memory data bus for emulator and host
// - assert wait request while memory cannot finish; host holds off
// - power-on preset resets host access logic; active-high copy made
// - host read with load-pager selected drives host data bit 0 low
// - emulator write to ROM-mapped address raises a break
// - respond to host transfers only while card select is low
// - load-mapper plus host write stores data bits 0-8 into mapper
// - load-pager plus host write latches data bits 0-5 into page register
// - host strobe latches the function code that selects commands
// - start-memory with valid address latches a host access request
// - host upper-byte line chooses the byte-lane write strobes
// - mapper gives active-low user flag to data control and write-strobe logic
// - memory write line low for every memory write
// - lower-lane strobe low when lower 8 bits are used
// - access to guarded-mapped address raises a break
// - host identification request clears the break lines
// - host reaches memory only while emulator reports memory free
// - upper-lane strobe low when upper 8 bits are used
module emc_ctrl #(
   parameter int AW = emc_pkg::MAP_AW,
   parameter int DW = emc_pkg::DATA_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host bus control
   input wire logic power_on_preset_n,
   input wire logic card_select_n,
   input wire logic host_strobe_n,
   input wire logic [2:0] host_func,
   input wire logic host_write_n,
   input wire logic host_read_n,
   input wire logic start_memory_n,
   input wire logic host_upper_byte_n,
   input wire logic host_ident_n,
   input wire logic [AW-1:0] host_addr,
   // host data, three signals per pin
   input wire logic [DW-1:0] host_data_n_in,
   output logic [DW-1:0] host_data_n_out,
   output logic [DW-1:0] host_data_n_oe,
   output logic host_wait_request_n,
   output logic power_on_preset_hi,
   // emulator side
   input wire logic [AW-1:0] emu_addr,
   input wire logic [DW-1:0] emu_data_n,
   input wire logic emu_write_cycle_n,
   input wire logic emu_upper_byte_n,
   input wire logic memory_free_n,
   output logic emu_break_n,
   output logic mem_break_status_n,
   // memory bus
   input wire logic [DW-1:0] memory_data_n_in,
   output logic [DW-1:0] memory_data_n_out,
   output logic [DW-1:0] memory_data_n_oe,
   output logic [emc_pkg::PAGE_W-1:0] mem_page,
   output logic mem_write_n,
   output logic mem_write_lower_n,
   output logic mem_write_upper_n
);
   localparam int SW = 11 + 3 + 2 * AW + 3 * DW;
   localparam logic [3:0] XFER_LAST = 4'(emc_pkg::MEM_ACCESS_CYC - 1);

   // lane strobes, active low: upper when upper-byte low, else lower
   function automatic logic [1:0] lanes_n(input logic upper_n);
      lanes_n = upper_n ? 2'b10 : 2'b01;
   endfunction : lanes_n

   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   logic preset_s, sel_s, stb_s, wr_s, rd_s, stm_s, upb_s, id_s, ewr_s, eupb_s, free_s;
   logic [2:0] func_s;
   logic [AW-1:0] haddr_s, eaddr_s;
   logic [DW-1:0] hdata_s, edata_s, mdata_s;
   logic stb_prev_ff, wr_prev_ff, stm_prev_ff;
   logic [2:0] func_ff;
   logic [emc_pkg::PAGE_W-1:0] page_ff;
   logic break_ff;
   emc_pkg::emc_state_type state_ff;
   logic [3:0] xfer_cnt_ff;
   logic host_wr_op_ff;
   logic load_mapper_n, load_pager_n, break_reset_n;
   logic user_region_n, rom_region_n, guarded_region_n;
   logic [emc_pkg::PAGE_W-1:0] bank;
   logic wr_event, stm_event, brk_set, emu_mem_write;
   logic [1:0] host_lanes_n, emu_lanes_n;

   // every pin passes two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= '1;
         sync2_ff <= '1;
      end else begin
         sync1_ff <= {power_on_preset_n, card_select_n, host_strobe_n, host_write_n,
                      host_read_n, start_memory_n, host_upper_byte_n, host_ident_n,
                      emu_write_cycle_n, emu_upper_byte_n, memory_free_n, host_func,
                      host_addr, emu_addr, host_data_n_in, emu_data_n, memory_data_n_in};
         sync2_ff <= sync1_ff;
      end
   end
   assign {preset_s, sel_s, stb_s, wr_s, rd_s, stm_s, upb_s, id_s, ewr_s, eupb_s, free_s,
           func_s, haddr_s, eaddr_s, hdata_s, edata_s, mdata_s} = sync2_ff;

   // edge history for the host strobes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stb_prev_ff <= 1'b1;
         wr_prev_ff <= 1'b1;
         stm_prev_ff <= 1'b1;
      end else begin
         stb_prev_ff <= stb_s;
         wr_prev_ff <= wr_s;
         stm_prev_ff <= stm_s;
      end
   end
   assign wr_event = !sel_s && wr_prev_ff && !wr_s;
   assign stm_event = !sel_s && stm_prev_ff && !stm_s;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_on_preset_hi <= 1'b1;
      end else begin
         power_on_preset_hi <= !preset_s;
      end
   end

   // function selector, taken on the falling strobe edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         func_ff <= emc_pkg::FUNC_RESET;
      end else if (!preset_s) begin
         func_ff <= emc_pkg::FUNC_RESET;
      end else if (!sel_s && stb_prev_ff && !stb_s) begin
         func_ff <= func_s;
      end
   end
   assign load_mapper_n = !(func_ff == emc_pkg::FUNC_LOAD_MAPPER);
   assign load_pager_n = !(func_ff == emc_pkg::FUNC_LOAD_PAGER);
   assign break_reset_n = !(!sel_s && !id_s && func_ff == emc_pkg::FUNC_IDENT);

   // 16k pager; bus is low-true so stored inverted
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_ff <= emc_pkg::PAGE_RESET;
      end else if (!preset_s) begin
         page_ff <= emc_pkg::PAGE_RESET;
      end else if (wr_event && !load_pager_n) begin
         page_ff <= ~hdata_s[emc_pkg::PAGE_W-1:0];
      end
   end

   emc_mapper #(.AW(AW)) u_mapper (
      .clk(clk),
      .rst(rst),
      .wr_en(wr_event && !load_mapper_n),
      .wr_addr(haddr_s),
      .wr_data(~hdata_s[emc_pkg::MAP_DW-1:0]),
      .rd_addr(eaddr_s),
      .user_region_n(user_region_n),
      .rom_region_n(rom_region_n),
      .guarded_region_n(guarded_region_n),
      .bank_ff(bank)
   );

   // illegal access: sticky, set beats reset
   assign brk_set = free_s &&
                    ((!rom_region_n && !ewr_s) || !guarded_region_n);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         break_ff <= 1'b0;
      end else if (brk_set) begin
         break_ff <= 1'b1;
      end else if (!break_reset_n) begin
         break_ff <= 1'b0;
      end
   end
   assign emu_break_n = !break_ff;
   assign mem_break_status_n = !break_ff;

   // host access sequencer; waits for the emulator to free memory
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= emc_pkg::ST_IDLE;
         xfer_cnt_ff <= 4'h0;
         host_wr_op_ff <= 1'b0;
      end else if (!preset_s) begin
         state_ff <= emc_pkg::ST_IDLE;
         xfer_cnt_ff <= 4'h0;
         host_wr_op_ff <= 1'b0;
      end else begin
         case (state_ff)
            emc_pkg::ST_IDLE: begin
               if (stm_event) begin
                  state_ff <= emc_pkg::ST_WAIT;
                  host_wr_op_ff <= !wr_s;
               end
            end
            emc_pkg::ST_WAIT: begin
               if (!free_s) begin
                  state_ff <= emc_pkg::ST_XFER;
                  xfer_cnt_ff <= 4'h0;
               end
            end
            emc_pkg::ST_XFER: begin
               if (xfer_cnt_ff == XFER_LAST) begin
                  state_ff <= emc_pkg::ST_DONE;
               end else begin
                  xfer_cnt_ff <= xfer_cnt_ff + 4'h1;
               end
            end
            default: begin
               if (stm_s) begin
                  state_ff <= emc_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end
   assign host_wait_request_n = !(state_ff == emc_pkg::ST_WAIT ||
                                  state_ff == emc_pkg::ST_XFER);

   // host data drive: read data, or pager status bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         host_data_n_out <= '1;
         host_data_n_oe <= '0;
      end else if (sel_s || rd_s) begin
         host_data_n_oe <= '0;
      end else if (!load_pager_n) begin
         host_data_n_out <= {{(DW-1){1'b1}}, 1'b0};
         host_data_n_oe <= {{(DW-1){1'b0}}, 1'b1};
      end else if (state_ff == emc_pkg::ST_XFER && !host_wr_op_ff) begin
         host_data_n_out <= mdata_s;
         host_data_n_oe <= '1;
      end
   end

   // shared memory bus and strobes; emulator only in user space
   assign emu_mem_write = free_s && !ewr_s && !user_region_n && rom_region_n;
   assign host_lanes_n = lanes_n(upb_s);
   assign emu_lanes_n = lanes_n(eupb_s);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         memory_data_n_out <= '1;
         memory_data_n_oe <= '0;
         mem_write_n <= 1'b1;
         mem_write_upper_n <= 1'b1;
         mem_write_lower_n <= 1'b1;
         mem_page <= emc_pkg::PAGE_RESET;
      end else if (state_ff == emc_pkg::ST_XFER) begin
         memory_data_n_out <= hdata_s;
         memory_data_n_oe <= {DW{host_wr_op_ff}};
         mem_write_n <= !host_wr_op_ff;
         mem_write_upper_n <= !host_wr_op_ff || host_lanes_n[1];
         mem_write_lower_n <= !host_wr_op_ff || host_lanes_n[0];
         mem_page <= page_ff;
      end else begin
         memory_data_n_out <= edata_s;
         memory_data_n_oe <= {DW{emu_mem_write}};
         mem_write_n <= !emu_mem_write;
         mem_write_upper_n <= !emu_mem_write || emu_lanes_n[1];
         mem_write_lower_n <= !emu_mem_write || emu_lanes_n[0];
         mem_page <= bank;
      end
   end

   AST_BREAK_ROM: assert property (@(posedge clk) disable iff (rst)
      (free_s && !rom_region_n && !ewr_s) |=> !emu_break_n)
      else $error("rom write did not break");
   AST_BREAK_GUARD: assert property (@(posedge clk) disable iff (rst)
      (free_s && !guarded_region_n) |=> (!emu_break_n && !mem_break_status_n))
      else $error("guarded access did not break");
   AST_BREAK_HOLD: assert property (@(posedge clk) disable iff (rst)
      (!mem_break_status_n && break_reset_n) |=> !mem_break_status_n)
      else $error("break released without reset");
   AST_BREAK_CLR: assert property (@(posedge clk) disable iff (rst)
      (!break_reset_n && !brk_set) |=> mem_break_status_n)
      else $error("break not cleared by ident");
   AST_PAGER: assert property (@(posedge clk) disable iff (rst)
      (wr_event && !load_pager_n && preset_s) |=> page_ff == ~$past(hdata_s[5:0]))
      else $error("pager not loaded");
   AST_LD0: assert property (@(posedge clk) disable iff (rst)
      (!sel_s && !rd_s && !load_pager_n) |=> (host_data_n_oe[0] && !host_data_n_out[0]))
      else $error("bit 0 not driven low");
   AST_WAIT: assert property (@(posedge clk) disable iff (rst)
      (stm_event && state_ff == emc_pkg::ST_IDLE && preset_s) |=> !host_wait_request_n)
      else $error("no wait request on start");
   AST_GRANT: assert property (@(posedge clk) disable iff (rst)
      (state_ff == emc_pkg::ST_WAIT && free_s) |=> state_ff != emc_pkg::ST_XFER)
      else $error("host granted while emulator busy");
   AST_NOSEL: assert property (@(posedge clk) disable iff (rst)
      sel_s |=> host_data_n_oe == '0)
      else $error("data driven while unselected");
   AST_PRESET: assert property (@(posedge clk) disable iff (rst)
      !preset_s |=> (state_ff == emc_pkg::ST_IDLE && power_on_preset_hi))
      else $error("preset not applied");
   AST_LANE: assert property (@(posedge clk) disable iff (rst)
      (!mem_write_lower_n || !mem_write_upper_n) |-> !mem_write_n)
      else $error("lane strobe without write");
endmodule : emc_ctrl

// [logic/emc_pkg.sv]
// shared constants for the emulation memory control block
package emc_pkg;
   // host command codes on the function lines
   localparam logic [2:0] FUNC_NONE = 3'h0;
   localparam logic [2:0] FUNC_LOAD_MAPPER = 3'h1;
   localparam logic [2:0] FUNC_LOAD_PAGER = 3'h2;
   localparam logic [2:0] FUNC_IDENT = 3'h3;
   // widths
   localparam int DATA_W = 16;
   localparam int MAP_AW = 8;
   localparam int MAP_DW = 9;
   localparam int PAGE_W = 6;
   // mapper entry fields, true-high in the stored entry
   localparam int MAP_USER_BIT = 0;
   localparam int MAP_ROM_BIT = 1;
   localparam int MAP_GUARD_BIT = 2;
   localparam int MAP_BANK_LSB = 3;
   // reset values
   localparam logic [2:0] FUNC_RESET = 3'h0;
   localparam logic [5:0] PAGE_RESET = 6'h00;
   localparam logic [8:0] MAP_ENTRY_RESET = 9'h000;
   // memory access time for one host transfer
   localparam int CLK_PERIOD_NS = 10;
   localparam int MEM_ACCESS_NS = 100;
   localparam int MEM_ACCESS_CYC = (MEM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host access sequencer, gray along the usual path
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_XFER = 2'b11,
      ST_DONE = 2'b10
   } emc_state_type;
endpackage : emc_pkg

// [logic/emc_mapper.sv]
// mapper ram: region flags and bank per emulator address block
`timescale 1ns/1ns
module emc_mapper #(
   parameter int AW = emc_pkg::MAP_AW
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [emc_pkg::MAP_DW-1:0] wr_data,
   // emulator lookup
   input wire logic [AW-1:0] rd_addr,
   output logic user_region_n,
   output logic rom_region_n,
   output logic guarded_region_n,
   output logic [emc_pkg::PAGE_W-1:0] bank_ff
);
   logic [emc_pkg::MAP_DW-1:0] map_mem [0:(1<<AW)-1];
   logic [emc_pkg::MAP_DW-1:0] entry_ff;

   // array left unreset; software loads it before use
   always_ff @(posedge clk) begin
      if (wr_en) begin
         map_mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         entry_ff <= emc_pkg::MAP_ENTRY_RESET;
      end else begin
         entry_ff <= map_mem[rd_addr];
      end
   end

   assign user_region_n = ~entry_ff[emc_pkg::MAP_USER_BIT];
   assign rom_region_n = ~entry_ff[emc_pkg::MAP_ROM_BIT];
   assign guarded_region_n = ~entry_ff[emc_pkg::MAP_GUARD_BIT];
   assign bank_ff = entry_ff[emc_pkg::MAP_BANK_LSB +: emc_pkg::PAGE_W];
endmodule : emc_mapper

// [verif/emc_mem_model.sv]
// memory bus partner: one byte-lane word per page
`timescale 1ns/1ns
module emc_mem_model (
   // clock
   input wire logic clk,
   // memory bus from the controller
   input wire logic [15:0] memory_data_n_out,
   input wire logic [5:0] mem_page,
   input wire logic mem_write_n,
   input wire logic mem_write_lower_n,
   input wire logic mem_write_upper_n,
   // read data back to the controller
   output logic [15:0] memory_data_n_in
);
   logic [15:0] mem_ff [64];
   // no address pins reach the card edge, so the page alone picks the word
   initial begin
      foreach (mem_ff[i]) mem_ff[i] = 16'hffff;
   end
   always @(posedge clk) begin
      if (!mem_write_n && !mem_write_upper_n) begin
         mem_ff[mem_page][15:8] <= memory_data_n_out[15:8];
      end
      if (!mem_write_n && !mem_write_lower_n) begin
         mem_ff[mem_page][7:0] <= memory_data_n_out[7:0];
      end
   end
   assign memory_data_n_in = mem_ff[mem_page];
endmodule : emc_mem_model

// [verif/tb_emulation_memory_control.sv]
// testbench for the emulation memory control block
`timescale 1ns/1ns
module tb_emulation_memory_control;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic power_on_preset_n = 1'b1, card_select_n = 1'b1, host_strobe_n = 1'b1;
   logic host_write_n = 1'b1, host_read_n = 1'b1, start_memory_n = 1'b1;
   logic host_upper_byte_n = 1'b1, host_ident_n = 1'b1, emu_write_cycle_n = 1'b1;
   logic emu_upper_byte_n = 1'b1, memory_free_n = 1'b1;
   logic [2:0] host_func = emc_pkg::FUNC_NONE;
   logic [7:0] host_addr = 8'h00, emu_addr = 8'h00;
   logic [15:0] host_data_n_in = 16'hffff, emu_data_n = 16'hffff;
   logic [15:0] host_data_n_out, host_data_n_oe, memory_data_n_in, memory_data_n_out;
   logic [15:0] memory_data_n_oe, d, seen_lanes;
   logic [15:0] exp_mem [64];
   logic [5:0] mem_page, page;
   logic host_wait_request_n, power_on_preset_hi, emu_break_n, mem_break_status_n;
   logic mem_write_n, mem_write_lower_n, mem_write_upper_n;
   int errors = 0;
   int total_checks = 0;

   emc_ctrl dut (.clk, .rst, .power_on_preset_n, .card_select_n, .host_strobe_n, .host_func,
      .host_write_n, .host_read_n, .start_memory_n, .host_upper_byte_n, .host_ident_n,
      .host_addr, .host_data_n_in, .host_data_n_out, .host_data_n_oe, .host_wait_request_n,
      .power_on_preset_hi, .emu_addr, .emu_data_n, .emu_write_cycle_n, .emu_upper_byte_n,
      .memory_free_n, .emu_break_n, .mem_break_status_n, .memory_data_n_in,
      .memory_data_n_out, .memory_data_n_oe, .mem_page, .mem_write_n, .mem_write_lower_n,
      .mem_write_upper_n);
   emc_mem_model mem (.clk, .memory_data_n_out, .mem_page, .mem_write_n, .mem_write_lower_n,
      .mem_write_upper_n, .memory_data_n_in);

   always #5 clk = ~clk;

   task automatic stop_test;
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic func(input logic [2:0] code);
      host_func = code;
      host_strobe_n = 1'b0;
      step(3);
      host_strobe_n = 1'b1;
      step(4);
   endtask : func
   task automatic hwrite(input logic [7:0] a, input logic [15:0] v);
      host_addr = a;
      host_data_n_in = ~v;
      host_write_n = 1'b0;
      step(6);
      host_write_n = 1'b1;
      step(2);
   endtask : hwrite
   task automatic brk(input logic [7:0] a, input logic wrn, input logic [15:0] exp);
      emu_addr = a;
      emu_write_cycle_n = wrn;
      step(8);
      chk({14'h0, emu_break_n, mem_break_status_n}, exp);
   endtask : brk
   task automatic clear_break;
      func(emc_pkg::FUNC_IDENT);
      host_ident_n = 1'b0;
      step(6);
      host_ident_n = 1'b1;
      func(emc_pkg::FUNC_NONE);
   endtask : clear_break
   // host memory cycle; the emulator holds memory for a while first
   task automatic access(input logic wr, input logic upb, input logic [15:0] pins);
      int n;
      host_write_n = ~wr;
      host_read_n = wr;
      host_upper_byte_n = upb;
      host_data_n_in = pins;
      start_memory_n = 1'b0;
      step(6);
      chk({15'h0, host_wait_request_n}, 16'h0000);
      step(20);
      chk({14'h0, host_wait_request_n, mem_write_n}, 16'h0001);
      memory_free_n = 1'b0;
      seen_lanes = 16'h0003;
      n = 0;
      while (host_wait_request_n !== 1'b1 && n < 60) begin
         if (mem_write_n === 1'b0) begin
            seen_lanes = {14'h0, mem_write_upper_n, mem_write_lower_n};
            chk({10'h0, mem_page}, {10'h0, page});
            chk(memory_data_n_out, pins);
         end
         step(1);
         n++;
      end
      if (n == 60) begin
         errors++;
         stop_test();
      end
      chk(seen_lanes, wr ? {14'h0, upb, ~upb} : 16'h0003);
      chk(memory_data_n_oe, {16{wr}});
      if (!wr) chk(host_data_n_oe, 16'hffff);
      if (wr && !upb) exp_mem[page][15:8] = pins[15:8];
      if (wr && upb) exp_mem[page][7:0] = pins[7:0];
      if (!wr) chk(host_data_n_out, exp_mem[page]);
      start_memory_n = 1'b1;
      host_write_n = 1'b1;
      host_read_n = 1'b1;
      memory_free_n = 1'b1;
      step(4);
   endtask : access

   initial begin
      void'($urandom(80));
      foreach (exp_mem[i]) exp_mem[i] = 16'hffff;
      step(4);
      rst = 1'b0;
      step(4);
      chk({15'h0, power_on_preset_hi}, 16'h0000);
      power_on_preset_n = 1'b0;
      step(6);
      chk({15'h0, power_on_preset_hi}, 16'h0001);
      power_on_preset_n = 1'b1;
      step(6);
      chk({15'h0, power_on_preset_hi}, 16'h0000);
      // a start while deselected must not stall the host
      start_memory_n = 1'b0;
      step(8);
      chk({15'h0, host_wait_request_n}, 16'h0001);
      start_memory_n = 1'b1;
      card_select_n = 1'b0;
      step(4);
      page = 6'($urandom);
      func(emc_pkg::FUNC_LOAD_PAGER);
      hwrite(8'h00, {10'h0, page});
      host_read_n = 1'b0;
      step(5);
      chk({14'h0, host_data_n_oe[0], host_data_n_out[0]}, 16'h0002);
      host_read_n = 1'b1;
      func(emc_pkg::FUNC_LOAD_MAPPER);
      hwrite(8'h10, 16'h0001);
      hwrite(8'h20, 16'h0002);
      hwrite(8'h30, 16'h0004);
      func(emc_pkg::FUNC_NONE);
      brk(8'h30, 1'b1, 16'h0000);
      brk(8'h10, 1'b1, 16'h0000);
      clear_break();
      brk(8'h10, 1'b1, 16'h0003);
      brk(8'h20, 1'b1, 16'h0003);
      brk(8'h20, 1'b0, 16'h0000);
      brk(8'h10, 1'b1, 16'h0000);
      clear_break();
      brk(8'h10, 1'b1, 16'h0003);
      // emulator store into user space, lower lane of the mapped bank
      emu_data_n = 16'($urandom);
      emu_write_cycle_n = 1'b0;
      step(4);
      chk({mem_write_n, mem_write_upper_n, mem_write_lower_n, 13'h0}, 16'h4000);
      chk({10'h0, mem_page}, 16'h0000);
      chk(memory_data_n_out, emu_data_n);
      chk(memory_data_n_oe, 16'hffff);
      exp_mem[0][7:0] = emu_data_n[7:0];
      emu_write_cycle_n = 1'b1;
      step(4);
      d = 16'($urandom);
      access(1'b1, 1'b0, d);
      access(1'b1, 1'b1, ~d);
      access(1'b0, 1'b1, 16'hffff);
      stop_test();
   end
endmodule : tb_emulation_memory_control
